// *** shared/csr_pkg.sv ***
// Contract
// - PLL powered down by default
// - code 00b runs PLL normally
// - divider code picks 2..6, default four
// - bypass bit clear routes through divider
// - source bit: 0 external, 1 VCO
// - PFD polarity bit 0 positive, 1 negative
// - external source keeps internal VCO off
// - reset restores routing defaults
// - calibration bit plus update starts calibration; for a repeat start the code needs the bit clear at the previous update
package csr_pkg;
    // ========================================
    // register indices (byte address = 4 * index)
    localparam logic [11:0] CSR_IDX_PWR = 12'h010;
    localparam logic [11:0] CSR_IDX_CAL = 12'h018;
    localparam logic [11:0] CSR_IDX_DIV = 12'h1E0;
    localparam logic [11:0] CSR_IDX_SRC = 12'h1E1;
    localparam logic [11:0] CSR_IDX_UPD = 12'h232;
    localparam logic [11:0] CSR_IDX_STAT = 12'h233;
    // ========================================
    // field positions and codes
    localparam int CSR_POL_BIT = 7;
    localparam int CSR_BYP_BIT = 0;
    localparam int CSR_SRC_BIT = 1;
    localparam logic [1:0] CSR_PD_NORMAL = 2'h0;
    localparam logic [1:0] CSR_PD_ASYNC = 2'h1;
    localparam logic [2:0] CSR_DIV_MIN = 3'h0;
    localparam logic [2:0] CSR_DIV_MAX = 3'h4;
    // ========================================
    // reset values
    localparam logic [7:0] CSR_RST_PWR = 8'h01;
    localparam logic [7:0] CSR_RST_CAL = 8'h00;
    localparam logic [7:0] CSR_RST_DIV = 8'h02;
    localparam logic [7:0] CSR_RST_SRC = 8'h00;
    // ========================================
    // timing: calibration busy time
    localparam int CSR_CAL_TIME_NS = 4000;
    localparam int CSR_CLK_NS = 40;
    localparam int CSR_CAL_CYCLES = CSR_CAL_TIME_NS / CSR_CLK_NS;
endpackage : csr_pkg

// *** shared/csr_cal_if.sv ***
`timescale 1ns/1ps
// calibration request and state between top and sequencer
interface csr_cal_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl (output start, input busy, input done);
    modport seq (input start, output busy, output done);
endinterface : csr_cal_if

// *** design/csr_cal_seq.sv ***
`timescale 1ns/1ps
module csr_cal_seq
    import csr_pkg::*;
#(
    parameter int CAL_CYCLES = CSR_CAL_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // request
    csr_cal_if.seq cal
);
    typedef enum logic [0:0] {CSR_IDLE, CSR_RUN} csr_cal_e;
    csr_cal_e state;
    logic [15:0] count;

    // ========================================
    // calibration timer, restarts are ignored while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= CSR_IDLE;
            count <= 16'h0000;
            cal.done <= 1'b0;
        end
        else if (clk_en)
        begin
            case (state)
                CSR_IDLE:
                begin
                    if (cal.start)
                    begin
                        state <= CSR_RUN;
                        count <= 16'(CAL_CYCLES - 1);
                        cal.done <= 1'b0;
                    end
                end
                CSR_RUN:
                begin
                    if (count == 16'h0000)
                    begin
                        state <= CSR_IDLE;
                        cal.done <= 1'b1;
                    end
                    else
                        count <= count - 16'h0001;
                end
                default: state <= CSR_IDLE;
            endcase
        end
    end
    assign cal.busy = (state == CSR_RUN);

    // the timer must not collapse to a single cycle
    property p_cal_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(cal.busy) && clk_en |-> cal.busy [*2];
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("calibration ended too soon");
endmodule : csr_cal_seq

// *** design/csr_clock_route.sv ***
`timescale 1ns/1ps
module csr_clock_route
    import csr_pkg::*;
#(
    parameter int CAL_CYCLES = CSR_CAL_CYCLES
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // routing controls, applied values, then calibration status
    output logic pll_pd_n,
    output logic pfd_neg,
    output logic vco_pwr,
    output logic src_vco,
    output logic div_bypass,
    output logic [2:0] div_ratio_m2,
    output logic cal_busy,
    output logic cal_done
);
    // ========================================
    // shadow registers written by software
    logic [7:0] reg_pwr;
    logic [7:0] reg_cal;
    logic [7:0] reg_div;
    logic [7:0] reg_src;
    logic cal_start;
    logic cal_prev;
    logic first_cal;

    csr_cal_if cal ();
    assign cal.start = cal_start;

    csr_cal_seq #(.CAL_CYCLES(CAL_CYCLES)) u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .cal(cal)
    );

    // ========================================
    // address decode
    function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction : hit

    // power code decode, shared by the pll and vco enables
    function automatic logic pll_on(input logic [7:0] r);
        return r[1:0] == CSR_PD_NORMAL;
    endfunction : pll_on

    wire acc = psel && penable && clk_en;
    wire wr = acc && pwrite && pstrb[0];
    wire hit_pwr = hit(paddr, CSR_IDX_PWR);
    wire hit_cal = hit(paddr, CSR_IDX_CAL);
    wire hit_div = hit(paddr, CSR_IDX_DIV);
    wire hit_src = hit(paddr, CSR_IDX_SRC);
    wire hit_upd = hit(paddr, CSR_IDX_UPD);
    wire hit_stat = hit(paddr, CSR_IDX_STAT);
    wire mapped = hit_pwr | hit_cal | hit_div | hit_src | hit_upd | hit_stat;
    // out-of-range divider codes are clamped to the largest ratio
    wire [2:0] div_safe = (reg_div[2:0] > CSR_DIV_MAX) ? CSR_DIV_MAX : reg_div[2:0];
    wire update = wr && hit_upd && pwdata[0];
    wire pwr_on = pll_on(reg_pwr);
    // repeat calibration needs a clear-then-set sequence across updates
    wire cal_go = update && reg_cal[0] && (first_cal || !cal_prev) && !cal.busy;
    wire [7:0] rd_mux = hit_pwr ? reg_pwr :
                        hit_cal ? reg_cal :
                        hit_div ? reg_div :
                        hit_src ? reg_src :
                        hit_stat ? {6'h00, cal.done, cal.busy} : 8'h00;

    // ========================================
    // register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reg_pwr <= CSR_RST_PWR;
            reg_cal <= CSR_RST_CAL;
            reg_div <= CSR_RST_DIV;
            reg_src <= CSR_RST_SRC;
        end
        else if (wr)
        begin
            if (hit_pwr)
                reg_pwr <= pwdata[7:0];
            if (hit_cal)
                reg_cal <= pwdata[7:0];
            if (hit_div)
                reg_div <= pwdata[7:0];
            if (hit_src)
                reg_src <= pwdata[7:0];
        end
    end

    // ========================================
    // applied configuration, loaded only on update
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_pd_n <= 1'b0;
            pfd_neg <= 1'b0;
            vco_pwr <= 1'b0;
            src_vco <= 1'b0;
            div_bypass <= 1'b0;
            div_ratio_m2 <= CSR_RST_DIV[2:0];
            cal_start <= 1'b0;
            cal_prev <= 1'b0;
            first_cal <= 1'b1;
        end
        else if (clk_en)
        begin
            cal_start <= cal_go;
            if (update)
            begin
                pll_pd_n <= pwr_on;
                pfd_neg <= reg_pwr[CSR_POL_BIT];
                src_vco <= reg_src[CSR_SRC_BIT];
                vco_pwr <= reg_src[CSR_SRC_BIT] && pwr_on;
                div_bypass <= reg_src[CSR_BYP_BIT];
                div_ratio_m2 <= div_safe;
                cal_prev <= reg_cal[0];
                if (cal_go)
                    first_cal <= 1'b0;
            end
        end
    end

    // ========================================
    // apb answer, single wait-free access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            cal_busy <= 1'b0;
            cal_done <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= {24'h000000, rd_mux};
            cal_busy <= cal.busy;
            cal_done <= cal.done;
        end
    end

    // ========================================
    // checks on stored and applied configuration
    // pll may not be on the cycle after an update whose power code has bit 0 set
    property p_pd_default;
        @(posedge pclk) disable iff (!presetn)
        pll_pd_n |-> !$past(reg_pwr[0]) || !$past(update);
    endproperty
    a_pd_default: assert property (p_pd_default)
        else $error("pll on while async power-down applied");

    // internal vco needs both the vco source and a running pll
    property p_vco_ext;
        @(posedge pclk) disable iff (!presetn)
        vco_pwr |-> src_vco && pll_pd_n;
    endproperty
    a_vco_ext: assert property (p_vco_ext)
        else $error("internal vco on with external source");

    // routing only moves on an update write
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        clk_en && !update |=> $stable(src_vco) && $stable(div_bypass);
    endproperty
    a_hold: assert property (p_hold)
        else $error("routing changed without update");

    // clamp keeps the ratio inside two to six
    property p_div_rng;
        @(posedge pclk) disable iff (!presetn)
        div_ratio_m2 <= CSR_DIV_MAX;
    endproperty
    a_div_rng: assert property (p_div_rng)
        else $error("divider ratio out of range");

    // start pulse, then sequencer busy, then the registered copy
    property p_cal_go;
        @(posedge pclk) disable iff (!presetn)
        clk_en && cal_go |=> cal_start ##2 cal_busy;
    endproperty
    a_cal_go: assert property (p_cal_go)
        else $error("calibration not started");

    // polarity follows the stored bit on update
    property p_pol;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update |=> pfd_neg == $past(reg_pwr[CSR_POL_BIT]);
    endproperty
    a_pol: assert property (p_pol)
        else $error("pfd polarity not applied");

    // source select follows the stored bit on update
    property p_src;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update |=> src_vco == $past(reg_src[CSR_SRC_BIT]);
    endproperty
    a_src: assert property (p_src)
        else $error("source select not applied");

    // bypass follows the stored bit on update
    property p_byp;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update |=> div_bypass == $past(reg_src[CSR_BYP_BIT]);
    endproperty
    a_byp: assert property (p_byp)
        else $error("bypass not applied");

    // run code turns the pll on, any other code keeps it off
    property p_pd_apply;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update |=> pll_pd_n == ($past(reg_pwr[1:0]) == CSR_PD_NORMAL);
    endproperty
    a_pd_apply: assert property (p_pd_apply)
        else $error("pll power code not applied");

    // async power-down code must switch the pll off
    property p_pd_async;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update && (reg_pwr[1:0] == CSR_PD_ASYNC) |=> !pll_pd_n;
    endproperty
    a_pd_async: assert property (p_pd_async)
        else $error("pll left on by power-down code");

    // ratio follows the clamped code on update
    property p_div_apply;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update |=> div_ratio_m2 == $past(div_safe);
    endproperty
    a_div_apply: assert property (p_div_apply)
        else $error("divider code not applied");

    // vco power follows source and power code together
    property p_vco_apply;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update |=> vco_pwr == $past(reg_src[CSR_SRC_BIT] && pwr_on);
    endproperty
    a_vco_apply: assert property (p_vco_apply)
        else $error("vco power not applied");

    // external source never leaves the internal vco running
    property p_ext_vco_off;
        @(posedge pclk) disable iff (!presetn)
        !src_vco |-> !vco_pwr;
    endproperty
    a_ext_vco_off: assert property (p_ext_vco_off)
        else $error("vco powered on external source");

    // a low enable freezes the pll enable, source select, ratio, read data and ready
    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(pll_pd_n) && $stable(src_vco) && $stable(div_ratio_m2)
            && $stable(prdata) && $stable(pready);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    // repeat request without a clear in between is ignored
    property p_cal_repeat;
        @(posedge pclk) disable iff (!presetn)
        clk_en && update && reg_cal[0] && cal_prev && !first_cal |=> !cal_start;
    endproperty
    a_cal_repeat: assert property (p_cal_repeat)
        else $error("calibration restarted without clear");

    // a start pulse never lands on a running timer
    property p_cal_stop;
        @(posedge pclk) disable iff (!presetn)
        cal_start |-> !cal.busy;
    endproperty
    a_cal_stop: assert property (p_cal_stop)
        else $error("calibration start while busy");

    // start enters the run state and clears the done flag
    property p_done_start;
        @(posedge pclk) disable iff (!presetn)
        cal_start && clk_en && !cal.busy |=> cal.busy && !cal.done;
    endproperty
    a_done_start: assert property (p_done_start)
        else $error("calibration start not taken");

    // power word is stored on its write, not applied
    property p_wr_pwr;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_pwr |=> reg_pwr == $past(pwdata[7:0]);
    endproperty
    a_wr_pwr: assert property (p_wr_pwr)
        else $error("power word not stored");

    // source word is stored on its write, not applied
    property p_wr_src;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_src |=> reg_src == $past(pwdata[7:0]);
    endproperty
    a_wr_src: assert property (p_wr_src)
        else $error("source word not stored");

    // divider word is stored on its write, not applied
    property p_wr_div;
        @(posedge pclk) disable iff (!presetn)
        wr && hit_div |=> reg_div == $past(pwdata[7:0]);
    endproperty
    a_wr_div: assert property (p_wr_div)
        else $error("divider word not stored");

    // busy output is the sequencer state one cycle late
    property p_busy_mirror;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> cal_busy == $past(cal.busy);
    endproperty
    a_busy_mirror: assert property (p_busy_mirror)
        else $error("busy output out of step");

    // done output is the sequencer flag one cycle late
    property p_done_mirror;
        @(posedge pclk) disable iff (!presetn)
        clk_en |=> cal_done == $past(cal.done);
    endproperty
    a_done_mirror: assert property (p_done_mirror)
        else $error("done output out of step");
endmodule : csr_clock_route

// *** dv/csr_far_side.sv ***
`timescale 1ns/1ps
// ========================================
// far-side source feeding the pre-divider
module csr_far_side #(
    parameter int EXT_MHZ = 2400,
    parameter int VCO_MHZ = 2000
)
(
    // routing from the block
    input wire logic src_vco,
    input wire logic div_bypass,
    input wire logic [2:0] div_ratio_m2,
    // rate at the channel dividers
    output int chan_mhz
);
    int src_mhz;
    // bypass only valid for a slow source, the bench sets it with both the 2000 and 2400 MHz sources
    assign src_mhz = src_vco ? VCO_MHZ : EXT_MHZ;
    assign chan_mhz = div_bypass ? src_mhz : src_mhz / (int'(div_ratio_m2) + 2);
endmodule : csr_far_side

// *** dv/clock_source_routing_config_bench.sv ***
`timescale 1ns/1ps
// ========================================
// bench for the clock source routing block
module clock_source_routing_config_bench;
    import csr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ce;
    logic pll_pd_n, pfd_neg, vco_pwr, src_vco, div_bypass, cal_busy, cal_done;
    logic [2:0] div_ratio_m2;
    logic [3:0] pstrb;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] seed, pins, w_pwr, w_div, w_src, a_pwr, a_div, a_src;
    logic [11:0] idx [4] = '{CSR_IDX_PWR, CSR_IDX_DIV, CSR_IDX_SRC, CSR_IDX_CAL};
    logic [31:0] rst [4] = '{32'h01, 32'h02, 32'h00, 32'h00};
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;
    int chan_mhz;
    assign pins = {pll_pd_n, pfd_neg, vco_pwr, src_vco, div_bypass, div_ratio_m2};
    csr_clock_route #(.CAL_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pll_pd_n(pll_pd_n), .pfd_neg(pfd_neg), .vco_pwr(vco_pwr), .src_vco(src_vco),
        .div_bypass(div_bypass), .div_ratio_m2(div_ratio_m2), .cal_busy(cal_busy),
        .cal_done(cal_done));
    csr_far_side i_far (.src_vco(src_vco), .div_bypass(div_bypass),
        .div_ratio_m2(div_ratio_m2), .chan_mhz(chan_mhz));
    // ========================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic [15:0] ad(input logic [11:0] i);
        return {2'b00, i, 2'b00};
    endfunction : ad
    // expected pins from the applied model copy
    function automatic logic [31:0] pins_exp();
        logic on;
        on = (a_pwr[1:0] == 2'h0);
        return {24'h0, on, a_pwr[7], a_src[1] & on, a_src[1], a_src[0],
            (a_div[2:0] > 3'h4) ? 3'h4 : a_div[2:0]};
    endfunction : pins_exp
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready, then an idle edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // write plus model update; fields only land on the update strobe
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == ad(CSR_IDX_PWR)) w_pwr = d[7:0];
        if (a == ad(CSR_IDX_DIV)) w_div = d[7:0];
        if (a == ad(CSR_IDX_SRC)) w_src = d[7:0];
        if (a == ad(CSR_IDX_UPD) && d[0]) {a_pwr, a_div, a_src} = {w_pwr, w_div, w_src};
    endtask : wr
    task automatic do_reset();
        presetn <= 1'b0;
        {w_pwr, w_div, w_src} = 24'h010200;
        {a_pwr, a_div, a_src} = 24'h010200;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    task automatic cal_wait();
        for (int n = 0; n < 10 && cal_busy !== 1'b1; n++) @(posedge pclk);
        chk(32'(cal_busy), 32'h1);
        for (int n = 0; n < 20 && cal_done !== 1'b1; n++) @(posedge pclk);
        apb(1'b0, ad(CSR_IDX_STAT), 32'h0);
        chk(rd, 32'h2);
    endtask : cal_wait
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // ========================================
    // clock and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        ce = 1'b1;
        seed = 8'h23;
        do_reset();
        chk(32'(pins), pins_exp());
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, ad(idx[i]), 32'h0);
            chk(rd, rst[i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            wr(ad(CSR_IDX_PWR), {24'h0, seed[7], 6'h0, seed[0]});
            wr(ad(CSR_IDX_DIV), 32'(i));
            wr(ad(CSR_IDX_SRC), {30'h0, seed[2:1]});
            chk(32'(pins), pins_exp());
            wr(ad(CSR_IDX_UPD), 32'h1);
            repeat (2) @(posedge pclk);
            chk(32'(pins), pins_exp());
        end
        // frozen enable: nothing may move
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'(pins), pins_exp());
        ce <= 1'b1;
        @(posedge pclk);
        wr(ad(CSR_IDX_SRC), 32'h2);
        wr(ad(CSR_IDX_PWR), 32'h0);
        wr(ad(CSR_IDX_CAL), 32'h1);
        wr(ad(CSR_IDX_UPD), 32'h1);
        cal_wait();
        chk(32'(chan_mhz <= 1600), 32'h1);
        wr(ad(CSR_IDX_UPD), 32'h1);
        repeat (3) @(posedge pclk);
        chk(32'(cal_busy), 32'h0);
        wr(ad(CSR_IDX_CAL), 32'h0);
        wr(ad(CSR_IDX_UPD), 32'h1);
        wr(ad(CSR_IDX_CAL), 32'h1);
        wr(ad(CSR_IDX_UPD), 32'h1);
        cal_wait();
        apb(1'b0, ad(12'h100), 32'h0);
        chk(rd, 32'h0);
        chk(32'(er), 32'h1);
        do_reset();
        chk(32'(pins), pins_exp());
        end_of_test();
    end
endmodule : clock_source_routing_config_bench
